// file: rtl/ifeb_pkg.sv
// Package with the register map, field positions and widths of the interrupt flag and enable bank.
package ifeb_pkg;

  localparam int REG_W      = 16;
  localparam int ADDR_W     = 3;
  localparam int PRIO_W     = 3;
  localparam int PRIO_VEC_W = REG_W * PRIO_W;
  localparam int CHAN_N     = 5;

  // Register indices on the plain register port.
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_FOUR   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_FIVE   = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_ENABLES_ZERO = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_ENABLES_ONE  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_ENABLES_TWO  = 3'h4;

  // Reset value of every flag and enable register.
  localparam logic [REG_W-1:0] RESET_VALUE = 16'h0000;
  localparam logic [PRIO_W-1:0] PRIO_OFF   = 3'h0;

  // Field positions, source flag register four and five.
  localparam int POS_CHARGE_TIME_UNIT_FLAG = 13;
  localparam int POS_VOLTAGE_DETECT_FLAG   = 8;
  localparam int POS_CHECKSUM_GEN_FLAG     = 3;
  localparam int POS_SERIAL2_ERROR_FLAG    = 2;
  localparam int POS_SERIAL1_ERROR_FLAG    = 1;
  localparam int POS_LOWPOWER_WAKE_FLAG    = 0;

  // Field positions, enable register zero.
  localparam int POS_NONVOLATILE_MEM_ENABLE    = 15;
  localparam int POS_CONVERTER_DONE_ENABLE     = 13;
  localparam int POS_SERIAL1_TRANSMIT_ENABLE   = 12;
  localparam int POS_SERIAL1_RECEIVE_ENABLE    = 11;
  localparam int POS_SYNC_SERIAL1_EVENT_ENABLE = 10;
  localparam int POS_SYNC_SERIAL1_FAULT_ENABLE = 9;
  localparam int POS_TIMER_THREE_ENABLE        = 8;
  localparam int POS_TIMER_TWO_ENABLE          = 7;
  localparam int POS_COMPARE_TWO_ENABLE        = 6;
  localparam int POS_CAPTURE_TWO_ENABLE        = 5;
  localparam int POS_TIMER_ONE_ENABLE          = 3;
  localparam int POS_COMPARE_ONE_ENABLE        = 2;
  localparam int POS_CAPTURE_ONE_ENABLE        = 1;
  localparam int POS_EXT_INPUT_ZERO_ENABLE     = 0;

  // Field positions, enable register one.
  localparam int POS_SERIAL2_TRANSMIT_ENABLE = 15;
  localparam int POS_SERIAL2_RECEIVE_ENABLE  = 14;
  localparam int POS_EXT_INPUT_TWO_ENABLE    = 13;
  localparam int POS_TIMER_FIVE_ENABLE       = 12;
  localparam int POS_TIMER_FOUR_ENABLE       = 11;
  localparam int POS_COMPARE_THREE_ENABLE    = 9;
  localparam int POS_EXT_INPUT_ONE_ENABLE    = 4;
  localparam int POS_PIN_CHANGE_ENABLE       = 3;
  localparam int POS_COMPARATOR_ENABLE       = 2;
  localparam int POS_TWOWIRE1_MASTER_ENABLE  = 1;
  localparam int POS_TWOWIRE1_SLAVE_ENABLE   = 0;

  // Field positions, enable register two.
  localparam int POS_CAPTURE_THREE_ENABLE     = 5;
  localparam int POS_SYNC_SERIAL2_EVENT_ENABLE = 1;
  localparam int POS_SYNC_SERIAL2_FAULT_ENABLE = 0;

  localparam logic [REG_W-1:0] ONE_BIT = 16'h0001;

  // Implemented bits; every other position reads zero and ignores writes.
  localparam logic [REG_W-1:0] MASK_FLAGS_FOUR = (ONE_BIT << POS_CHARGE_TIME_UNIT_FLAG)
    | (ONE_BIT << POS_VOLTAGE_DETECT_FLAG) | (ONE_BIT << POS_CHECKSUM_GEN_FLAG)
    | (ONE_BIT << POS_SERIAL2_ERROR_FLAG) | (ONE_BIT << POS_SERIAL1_ERROR_FLAG);
  localparam logic [REG_W-1:0] MASK_FLAGS_FIVE = ONE_BIT << POS_LOWPOWER_WAKE_FLAG;
  localparam logic [REG_W-1:0] MASK_ENABLES_ZERO = (ONE_BIT << POS_NONVOLATILE_MEM_ENABLE)
    | (ONE_BIT << POS_CONVERTER_DONE_ENABLE) | (ONE_BIT << POS_SERIAL1_TRANSMIT_ENABLE)
    | (ONE_BIT << POS_SERIAL1_RECEIVE_ENABLE) | (ONE_BIT << POS_SYNC_SERIAL1_EVENT_ENABLE)
    | (ONE_BIT << POS_SYNC_SERIAL1_FAULT_ENABLE) | (ONE_BIT << POS_TIMER_THREE_ENABLE)
    | (ONE_BIT << POS_TIMER_TWO_ENABLE) | (ONE_BIT << POS_COMPARE_TWO_ENABLE)
    | (ONE_BIT << POS_CAPTURE_TWO_ENABLE) | (ONE_BIT << POS_TIMER_ONE_ENABLE)
    | (ONE_BIT << POS_COMPARE_ONE_ENABLE) | (ONE_BIT << POS_CAPTURE_ONE_ENABLE)
    | (ONE_BIT << POS_EXT_INPUT_ZERO_ENABLE);
  localparam logic [REG_W-1:0] MASK_ENABLES_ONE = (ONE_BIT << POS_SERIAL2_TRANSMIT_ENABLE)
    | (ONE_BIT << POS_SERIAL2_RECEIVE_ENABLE) | (ONE_BIT << POS_EXT_INPUT_TWO_ENABLE)
    | (ONE_BIT << POS_TIMER_FIVE_ENABLE) | (ONE_BIT << POS_TIMER_FOUR_ENABLE)
    | (ONE_BIT << POS_COMPARE_THREE_ENABLE) | (ONE_BIT << POS_EXT_INPUT_ONE_ENABLE)
    | (ONE_BIT << POS_PIN_CHANGE_ENABLE) | (ONE_BIT << POS_COMPARATOR_ENABLE)
    | (ONE_BIT << POS_TWOWIRE1_MASTER_ENABLE) | (ONE_BIT << POS_TWOWIRE1_SLAVE_ENABLE);
  localparam logic [REG_W-1:0] MASK_ENABLES_TWO = (ONE_BIT << POS_CAPTURE_THREE_ENABLE)
    | (ONE_BIT << POS_SYNC_SERIAL2_EVENT_ENABLE) | (ONE_BIT << POS_SYNC_SERIAL2_FAULT_ENABLE);

endpackage

// file: rtl/ifeb_req_if.sv
// Interface carrying one register's flags, enables and priorities to a request gate.
`timescale 1ns/1ps
`default_nettype none

interface ifeb_req_if;
  logic [ifeb_pkg::REG_W-1:0]      flags;
  logic [ifeb_pkg::REG_W-1:0]      enables;
  logic [ifeb_pkg::PRIO_VEC_W-1:0] prio;
  logic [ifeb_pkg::REG_W-1:0]      req;
  logic [ifeb_pkg::PRIO_W-1:0]     level;

  modport gate (input flags, input enables, input prio, output req, output level);
  modport owner (output flags, output enables, output prio, input req, input level);
endinterface

`default_nettype wire

// file: rtl/ifeb_gate.sv
// Request gate: forwards flagged, enabled, non-zero priority sources of one register.
`timescale 1ns/1ps
`default_nettype none

module ifeb_gate (
  input wire logic clk,
  input wire logic rst,
  ifeb_req_if.gate port_bus
);
  import ifeb_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0]  req;
    logic [PRIO_W-1:0] level;
  } ifeb_gate_state_t;

  ifeb_gate_state_t st;
  ifeb_gate_state_t next_st;
  logic [REG_W-1:0]  hit;
  logic [PRIO_W-1:0] code [REG_W];

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  for (i = 0; i < REG_W; i++) begin : g_bit
    assign hit[i]  = port_bus.flags[i] & port_bus.enables[i] & (port_bus.prio[i*PRIO_W +: PRIO_W] != PRIO_OFF);
    assign code[i] = hit[i] ? port_bus.prio[i*PRIO_W +: PRIO_W] : PRIO_OFF;

    prio_zero_block_a: assert property (
      @(posedge clk) disable iff (rst)
      (port_bus.prio[i*PRIO_W +: PRIO_W] == PRIO_OFF) |=> !st.req[i])
      else $error("Source with priority code zero was forwarded.");
  end

  always_comb begin
    next_st     = st;
    next_st.req = hit;
    next_st.level = PRIO_OFF;
    for (int k = 0; k < REG_W; k++) begin
      if (code[k] > next_st.level) begin
        next_st.level = code[k];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port_bus.req   = st.req;
  assign port_bus.level = st.level;

  ////////////////////////////////////////////////////////////////////////////
  req_gate_a: assert property (
    @(posedge clk) disable iff (rst)
    ##1 st.req == ($past(port_bus.flags) & $past(port_bus.enables) & $past(hit)))
    else $error("Forwarded request differs from flag and enable.");

  req_level_a: assert property (
    @(posedge clk) disable iff (rst)
    (st.req == '0) |-> (st.level == PRIO_OFF))
    else $error("Level shown without any forwarded request.");

endmodule // ifeb_gate

`default_nettype wire

// file: rtl/ifeb_top.sv
// Interrupt flag registers four and five and enable registers zero to two, with request gating.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ifeb_top (
  input  wire logic                               CLK_SYS,
  input  wire logic                               RST,
  input  wire logic [ifeb_pkg::ADDR_W-1:0]        REG_ADDR,
  input  wire logic [ifeb_pkg::REG_W-1:0]         REG_WDATA,
  input  wire logic                               REG_WR,
  input  wire logic                               REG_RD,
  output logic      [ifeb_pkg::REG_W-1:0]         REG_RDATA,
  input  wire logic [ifeb_pkg::REG_W-1:0]         SET_FLAGS_FOUR,
  input  wire logic [ifeb_pkg::REG_W-1:0]         SET_FLAGS_FIVE,
  input  wire logic [ifeb_pkg::REG_W-1:0]         FLAGS_ZERO_IN,
  input  wire logic [ifeb_pkg::REG_W-1:0]         FLAGS_ONE_IN,
  input  wire logic [ifeb_pkg::REG_W-1:0]         FLAGS_TWO_IN,
  input  wire logic [ifeb_pkg::REG_W-1:0]         ENABLES_FOUR_IN,
  input  wire logic [ifeb_pkg::REG_W-1:0]         ENABLES_FIVE_IN,
  input  wire logic [ifeb_pkg::PRIO_VEC_W-1:0]    PRIO_ZERO,
  input  wire logic [ifeb_pkg::PRIO_VEC_W-1:0]    PRIO_ONE,
  input  wire logic [ifeb_pkg::PRIO_VEC_W-1:0]    PRIO_TWO,
  input  wire logic [ifeb_pkg::PRIO_VEC_W-1:0]    PRIO_FOUR,
  input  wire logic [ifeb_pkg::PRIO_VEC_W-1:0]    PRIO_FIVE,
  output logic      [ifeb_pkg::REG_W-1:0]         FLAGS_FOUR,
  output logic      [ifeb_pkg::REG_W-1:0]         FLAGS_FIVE,
  output logic      [ifeb_pkg::REG_W-1:0]         ENABLES_ZERO,
  output logic      [ifeb_pkg::REG_W-1:0]         ENABLES_ONE,
  output logic      [ifeb_pkg::REG_W-1:0]         ENABLES_TWO,
  output logic      [ifeb_pkg::REG_W-1:0]         REQ_ZERO,
  output logic      [ifeb_pkg::REG_W-1:0]         REQ_ONE,
  output logic      [ifeb_pkg::REG_W-1:0]         REQ_TWO,
  output logic      [ifeb_pkg::REG_W-1:0]         REQ_FOUR,
  output logic      [ifeb_pkg::REG_W-1:0]         REQ_FIVE,
  output logic      [ifeb_pkg::PRIO_W-1:0]        REQ_LEVEL
);
  import ifeb_pkg::*;

  typedef struct packed {
    logic [REG_W-1:0]  flags_four;
    logic [REG_W-1:0]  flags_five;
    logic [REG_W-1:0]  enables_zero;
    logic [REG_W-1:0]  enables_one;
    logic [REG_W-1:0]  enables_two;
    logic [REG_W-1:0]  rdata;
    logic [PRIO_W-1:0] level;
  } ifeb_state_t;

  ifeb_state_t st;
  ifeb_state_t next_st;

  logic [REG_W-1:0]      chan_flags [CHAN_N];
  logic [REG_W-1:0]      chan_en    [CHAN_N];
  logic [PRIO_VEC_W-1:0] chan_prio  [CHAN_N];
  logic [REG_W-1:0]      chan_req   [CHAN_N];
  logic [PRIO_W-1:0]     chan_level [CHAN_N];

  ifeb_req_if chan [CHAN_N] ();

  ////////////////////////////////////////////////////////////////////////////
  // Channels 0 to 2 pair outside flags with local enables; 3 and 4 the reverse.
  // Outside flags are masked with the enable layout, which matches their own.
  assign chan_flags[0] = FLAGS_ZERO_IN & MASK_ENABLES_ZERO;
  assign chan_flags[1] = FLAGS_ONE_IN & MASK_ENABLES_ONE;
  assign chan_flags[2] = FLAGS_TWO_IN & MASK_ENABLES_TWO;
  assign chan_flags[3] = st.flags_four;
  assign chan_flags[4] = st.flags_five;
  assign chan_en[0]    = st.enables_zero;
  assign chan_en[1]    = st.enables_one;
  assign chan_en[2]    = st.enables_two;
  assign chan_en[3]    = ENABLES_FOUR_IN & MASK_FLAGS_FOUR;
  assign chan_en[4]    = ENABLES_FIVE_IN & MASK_FLAGS_FIVE;
  assign chan_prio[0]  = PRIO_ZERO;
  assign chan_prio[1]  = PRIO_ONE;
  assign chan_prio[2]  = PRIO_TWO;
  assign chan_prio[3]  = PRIO_FOUR;
  assign chan_prio[4]  = PRIO_FIVE;

  genvar c;
  for (c = 0; c < CHAN_N; c++) begin : g_chan
    assign chan[c].flags   = chan_flags[c];
    assign chan[c].enables = chan_en[c];
    assign chan[c].prio    = chan_prio[c];
    assign chan_req[c]     = chan[c].req;
    assign chan_level[c]   = chan[c].level;

    ifeb_gate u_gate (
      .clk      (CLK_SYS),
      .rst      (RST),
      .port_bus (chan[c].gate)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st       = st;
    next_st.rdata = RESET_VALUE;

    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_FLAGS_FOUR:   next_st.rdata = st.flags_four & MASK_FLAGS_FOUR;
        ADDR_FLAGS_FIVE:   next_st.rdata = st.flags_five & MASK_FLAGS_FIVE;
        ADDR_ENABLES_ZERO: next_st.rdata = st.enables_zero & MASK_ENABLES_ZERO;
        ADDR_ENABLES_ONE:  next_st.rdata = st.enables_one & MASK_ENABLES_ONE;
        ADDR_ENABLES_TWO:  next_st.rdata = st.enables_two & MASK_ENABLES_TWO;
        default:           next_st.rdata = RESET_VALUE;
      endcase
    end

    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_FLAGS_FOUR:   next_st.flags_four   = REG_WDATA;
        ADDR_FLAGS_FIVE:   next_st.flags_five   = REG_WDATA;
        ADDR_ENABLES_ZERO: next_st.enables_zero = REG_WDATA;
        ADDR_ENABLES_ONE:  next_st.enables_one  = REG_WDATA;
        ADDR_ENABLES_TWO:  next_st.enables_two  = REG_WDATA;
        default:           next_st.flags_four   = st.flags_four;
      endcase
    end

    next_st.flags_four = next_st.flags_four | SET_FLAGS_FOUR;
    next_st.flags_five = next_st.flags_five | SET_FLAGS_FIVE;

    next_st.flags_four = next_st.flags_four & MASK_FLAGS_FOUR;
    next_st.flags_five = next_st.flags_five & MASK_FLAGS_FIVE;
    next_st.enables_zero = next_st.enables_zero & MASK_ENABLES_ZERO;
    next_st.enables_one = next_st.enables_one & MASK_ENABLES_ONE;
    next_st.enables_two = next_st.enables_two & MASK_ENABLES_TWO;

    next_st.level = PRIO_OFF;
    for (int k = 0; k < CHAN_N; k++) begin
      if (chan_level[k] > next_st.level) begin
        next_st.level = chan_level[k];
      end
    end
  end

  // All local flags and enables clear at reset; channels 3 and 4 can forward once hardware sets a flag under an outside enable.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign REG_RDATA    = st.rdata;
  assign FLAGS_FOUR   = st.flags_four;
  assign FLAGS_FIVE   = st.flags_five;
  assign ENABLES_ZERO = st.enables_zero;
  assign ENABLES_ONE  = st.enables_one;
  assign ENABLES_TWO  = st.enables_two;
  assign REQ_ZERO     = chan_req[0];
  assign REQ_ONE      = chan_req[1];
  assign REQ_TWO      = chan_req[2];
  assign REQ_FOUR     = chan_req[3];
  assign REQ_FIVE     = chan_req[4];
  assign REQ_LEVEL    = st.level;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  flag_set_four_a: assert property (
    (|(SET_FLAGS_FOUR & MASK_FLAGS_FOUR))
      |=> ((st.flags_four & $past(SET_FLAGS_FOUR & MASK_FLAGS_FOUR)) == $past(SET_FLAGS_FOUR & MASK_FLAGS_FOUR)))
    else $error("Hardware set of flag register four was lost.");

  flag_hold_a: assert property (
    (!REG_WR && SET_FLAGS_FOUR == '0 && SET_FLAGS_FIVE == '0)
      |=> ($stable(st.flags_four) && $stable(st.flags_five)))
    else $error("Flag changed without a set or a write.");

  set_beats_write_a: assert property (
    (REG_WR && REG_ADDR == ADDR_FLAGS_FOUR && REG_WDATA == '0 && SET_FLAGS_FOUR != '0)
      |=> (st.flags_four == $past(SET_FLAGS_FOUR & MASK_FLAGS_FOUR)))
    else $error("Software clear won over a same-cycle hardware set.");

  read_flags_a: assert property (
    (REG_RD && REG_ADDR == ADDR_FLAGS_FOUR) |=> (REG_RDATA == $past(st.flags_four)))
    else $error("Read of flag register four returned wrong data.");

  read_only_once_a: assert property (
    (!REG_RD) |=> (REG_RDATA == RESET_VALUE))
    else $error("Read data stood outside the cycle after a read.");

  flags_five_write_a: assert property (
    (REG_WR && REG_ADDR == ADDR_FLAGS_FIVE && SET_FLAGS_FIVE == '0)
      |=> (st.flags_five == ($past(REG_WDATA) & MASK_FLAGS_FIVE)))
    else $error("Flag register five write mismatch.");

  flags_four_mask_a: assert property (
    (st.flags_four & ~MASK_FLAGS_FOUR) == '0)
    else $error("Unimplemented bit set in flag register four.");

  enable_zero_write_a: assert property (
    (REG_WR && REG_ADDR == ADDR_ENABLES_ZERO) ##1 (!REG_WR)[*2]
      |-> (st.enables_zero == ($past(REG_WDATA, 2) & MASK_ENABLES_ZERO)))
    else $error("Enable register zero did not keep the written value.");

  enable_one_write_a: assert property (
    (REG_WR && REG_ADDR == ADDR_ENABLES_ONE) |=> (st.enables_one == ($past(REG_WDATA) & MASK_ENABLES_ONE)))
    else $error("Enable register one write mismatch.");

  enable_two_write_a: assert property (
    (REG_WR && REG_ADDR == ADDR_ENABLES_TWO) |=> (st.enables_two == ($past(REG_WDATA) & MASK_ENABLES_TWO)))
    else $error("Enable register two write mismatch.");

  enable_read_a: assert property (
    (REG_RD && REG_ADDR == ADDR_ENABLES_ONE) |=> (REG_RDATA == $past(st.enables_one)))
    else $error("Read of enable register one returned wrong data.");

  unmapped_read_a: assert property (
    (REG_RD && REG_ADDR > ADDR_ENABLES_TWO) |=> (REG_RDATA == RESET_VALUE))
    else $error("Unmapped address returned non-zero data.");

  enable_block_a: assert property (
    (st.enables_zero == '0) |=> ##1 (REQ_ZERO == '0) or ##1 ($past(st.enables_zero) != '0))
    else $error("Request forwarded while its enable was zero.");

  request_flag_a: assert property (
    (st.flags_four == '0) ##1 (st.flags_four == '0) |=> (REQ_FOUR == '0))
    else $error("Request forwarded without its flag.");

endmodule // ifeb_top

`default_nettype wire

// file: dv/ifeb_src_model.sv
// Peripheral request source model: turns event levels into one-cycle flag set pulses.
`timescale 1ns/1ps
`default_nettype none

module ifeb_src_model (
  input  wire logic [ifeb_pkg::REG_W-1:0] ev_four,
  input  wire logic [ifeb_pkg::REG_W-1:0] ev_five,
  input  wire logic                       clk,
  input  wire logic                       rst,
  output logic      [ifeb_pkg::REG_W-1:0] set_four,
  output logic      [ifeb_pkg::REG_W-1:0] set_five
);
  import ifeb_pkg::*;
  logic [REG_W-1:0] ev_four_q;
  logic [REG_W-1:0] ev_five_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_four_q <= 16'h0000;
      ev_five_q <= 16'h0000;
    end else begin
      ev_four_q <= ev_four;
      ev_five_q <= ev_five;
    end
  end
  // A held event must not set the flag again after software cleared it, so only new events pulse.
  assign set_four = ev_four & ~ev_four_q;
  assign set_five = ev_five & ~ev_five_q;
endmodule // ifeb_src_model

`default_nettype wire

// file: dv/ifeb_top_tb.sv
// Self-checking bench for the flag and enable bank, with random and corner traffic.
`timescale 1ns/1ps
`default_nettype none

module interrupt_flag_enable_bank_tb_top;
  import ifeb_pkg::*;
  // Implemented bits per register index; unmapped indices hold nothing.
  localparam logic [REG_W-1:0] MSK [5] = '{16'h210E, 16'h0001, 16'hBFEF, 16'hFA1F, 16'h0023};
  logic                  CLK_SYS;
  logic                  RST;
  logic                  REG_WR;
  logic                  REG_RD;
  logic [ADDR_W-1:0]     REG_ADDR;
  logic [REG_W-1:0]      REG_WDATA;
  logic [REG_W-1:0]      REG_RDATA;
  logic [REG_W-1:0]      ev_four;
  logic [REG_W-1:0]      ev_five;
  logic [REG_W-1:0]      set_four;
  logic [REG_W-1:0]      set_five;
  logic [REG_W-1:0]      fl_in [3];
  logic [REG_W-1:0]      en_in [2];
  logic [PRIO_VEC_W-1:0] prio [5];
  logic [REG_W-1:0]      fl_out [2];
  logic [REG_W-1:0]      en_out [3];
  logic [REG_W-1:0]      req [5];
  logic [PRIO_W-1:0]     lvl;
  logic [REG_W-1:0]      sh [5];
  logic [ADDR_W-1:0]     a;
  int                    n_fail;
  int                    samples_checked;

  ifeb_src_model u_src (.clk(CLK_SYS), .rst(RST), .ev_four(ev_four), .ev_five(ev_five),
    .set_four(set_four), .set_five(set_five));

  ifeb_top DUT (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .SET_FLAGS_FOUR(set_four), .SET_FLAGS_FIVE(set_five),
    .FLAGS_ZERO_IN(fl_in[0]), .FLAGS_ONE_IN(fl_in[1]), .FLAGS_TWO_IN(fl_in[2]),
    .ENABLES_FOUR_IN(en_in[0]), .ENABLES_FIVE_IN(en_in[1]),
    .PRIO_ZERO(prio[0]), .PRIO_ONE(prio[1]), .PRIO_TWO(prio[2]), .PRIO_FOUR(prio[3]), .PRIO_FIVE(prio[4]),
    .FLAGS_FOUR(fl_out[0]), .FLAGS_FIVE(fl_out[1]),
    .ENABLES_ZERO(en_out[0]), .ENABLES_ONE(en_out[1]), .ENABLES_TWO(en_out[2]),
    .REQ_ZERO(req[0]), .REQ_ONE(req[1]), .REQ_TWO(req[2]), .REQ_FOUR(req[3]), .REQ_FIVE(req[4]),
    .REQ_LEVEL(lvl));

  ////////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [REG_W-1:0] gate(input logic [REG_W-1:0] f, input logic [REG_W-1:0] e,
                                            input logic [PRIO_VEC_W-1:0] p);
    logic [REG_W-1:0] r;
    for (int i = 0; i < REG_W; i++) r[i] = f[i] & e[i] & (p[3*i+:3] != 3'h0);
    return r;
  endfunction

  function automatic logic [PRIO_W-1:0] peak(input logic [REG_W-1:0] r, input logic [PRIO_VEC_W-1:0] p,
                                             input logic [PRIO_W-1:0] cur);
    logic [PRIO_W-1:0] m = cur;
    for (int i = 0; i < REG_W; i++) if (r[i] && p[3*i+:3] > m) m = p[3*i+:3];
    return m;
  endfunction

  task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_level(input logic [PRIO_W-1:0] got, input logic [PRIO_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: level %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic drive(input logic we, input logic re, input logic [ADDR_W-1:0] ad,
                       input logic [REG_W-1:0] d, input logic [REG_W-1:0] e4, input logic [REG_W-1:0] e5);
    @(posedge CLK_SYS);
    REG_WR <= we;
    REG_RD <= re;
    REG_ADDR <= ad;
    REG_WDATA <= d;
    ev_four <= e4;
    ev_five <= e5;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [REG_W-1:0] d,
                    input logic [REG_W-1:0] e4, input logic [REG_W-1:0] e5);
    drive(1'b1, 1'b0, ad, d, e4, e5);
    if (ad < 3'h5) sh[ad] = d & MSK[ad];
    sh[0] = sh[0] | (e4 & MSK[0]);
    sh[1] = sh[1] | (e5 & MSK[1]);
    drive(1'b0, 1'b0, ad, d, 16'h0000, 16'h0000);
  endtask

  // Read data stand one cycle only, so they are taken just after the answering edge.
  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [REG_W-1:0] exp);
    drive(1'b0, 1'b1, ad, 16'h0000, 16'h0000, 16'h0000);
    drive(1'b0, 1'b0, ad, 16'h0000, 16'h0000, 16'h0000);
    #1 chk(REG_RDATA, exp);
    @(posedge CLK_SYS);
    #1 chk(REG_RDATA, 16'h0000);
  endtask

  task automatic chk_all();
    logic [REG_W-1:0]  r [5];
    logic [PRIO_W-1:0] l;
    repeat (3) @(posedge CLK_SYS);
    #1;
    for (int i = 0; i < 3; i++) r[i] = gate(fl_in[i] & MSK[i+2], sh[i+2], prio[i]);
    r[3] = gate(sh[0], en_in[0] & MSK[0], prio[3]);
    r[4] = gate(sh[1], en_in[1] & MSK[1], prio[4]);
    l = 3'h0;
    for (int i = 0; i < 5; i++) l = peak(r[i], prio[i], l);
    for (int i = 0; i < 2; i++) chk(fl_out[i], sh[i]);
    for (int i = 0; i < 3; i++) chk(en_out[i], sh[i+2]);
    for (int i = 0; i < 5; i++) chk(req[i], r[i]);
    chk_level(lvl, l);
  endtask

  task automatic rst_dut();
    @(posedge CLK_SYS);
    RST <= 1'b1;
    repeat (10) @(posedge CLK_SYS);
    RST <= 1'b0;
    for (int i = 0; i < 5; i++) sh[i] = 16'h0000;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    repeat (5000) @(posedge CLK_SYS);
    n_fail++;
    end_sim();
  end

  initial begin
    {RST, REG_WR, REG_RD, REG_ADDR, REG_WDATA, ev_four, ev_five} = '0;
    RST = 1'b1;
    for (int i = 0; i < 5; i++) prio[i] = '0;
    fl_in = '{3{16'h0000}};
    en_in = '{2{16'h0000}};
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(23468));
    rst_dut();
    for (int k = 0; k < 8; k++) rd(3'(k), 16'h0000);
    for (int k = 0; k < 8; k++) begin
      wr(3'(k), 16'hFFFF, 16'h0000, 16'h0000);
      rd(3'(k), (k < 5) ? MSK[k] : 16'h0000);
    end
    wr(ADDR_FLAGS_FOUR, 16'h0000, 16'hFFFF, 16'h0000);
    rd(ADDR_FLAGS_FOUR, 16'h210E);
    wr(ADDR_FLAGS_FIVE, 16'h0000, 16'h0000, 16'hFFFF);
    rd(ADDR_FLAGS_FIVE, 16'h0001);
    for (int n = 0; n < 48; n++) begin
      @(posedge CLK_SYS);
      for (int i = 0; i < 3; i++) fl_in[i] <= 16'($urandom());
      for (int i = 0; i < 2; i++) en_in[i] <= 16'($urandom());
      for (int i = 0; i < 5; i++) prio[i] <= 48'({$urandom(), $urandom()}) & {16{3'(n)}};
      a = 3'($urandom());
      wr(a, 16'($urandom()), (n % 3 == 0) ? 16'($urandom()) : 16'h0000, 16'($urandom_range(0, 1)));
      chk_all();
      rd(a, (a < 3'h5) ? sh[a] : 16'h0000);
      if (n == 24) begin
        rst_dut();
        chk_all();
      end
    end
    end_sim();
  end
endmodule // interrupt_flag_enable_bank_tb_top

`default_nettype wire
